// file: rlfa_agent.v
// Notes on behaviour
// - Power-on or bus reset puts agents in Reset.
// - Login response written to requested address.
// - Link with top bit set ends list.
// - Pointer write after a login moves Reset to Active, fetching.
// - Doorbell ignored while agent in Reset.
// - Fetch until storage full or null link.
// - Never reordered; blocks run in fetch order.
// - Direction zero reads initiator, one writes.
// - Status block written after each block.
// - Finish all fetched blocks, then Suspended.
// - Doorbell while suspended returns agent Active.
// - Resume rereads old last block link.
// - Doorbell ignored while Active before null.
// - Cycle repeats until reset or error.
// - One login per logical unit at most.
// - Blocks fetched only from login's list.
// - Ordered execution, strictly in queue order.
`include "rlfa_defines.vh"

module rlfa_agent (
    input wire clock_i,
    input wire rst_n_i,
    input wire bus_reset_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    output reg mem_req_o,
    output reg mem_write_o,
    output reg [31:0] mem_addr_o,
    output reg [31:0] mem_wdata_o,
    input wire mem_ack_i,
    input wire mem_err_i,
    input wire [31:0] mem_rdata_i,
    output reg [31:0] dout_o,
    output reg dout_valid_o,
    input wire [31:0] din_i,
    output reg din_take_o,
    input wire [15:0] dev_status_i,
    output reg irq_o
);

    // Register decode used by reads and writes alike.
    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    reg br_s1;
    reg br_s2;
    reg [1:0] agent;
    reg [2:0] eng;
    reg [1:0] widx;
    reg [15:0] xcnt;
    reg login_pend;
    reg [31:0] login_addr;
    reg [31:0] resp_addr;
    reg [31:0] drop_addr;
    reg [1:0] lun;
    reg [31:0] resp_code;
    reg fetch_pend;
    reg relink_pend;
    reg null_seen;
    reg [31:0] fetch_addr;
    reg [31:0] last_addr;
    reg [31:0] t_link;
    reg [31:0] t_data;
    reg [31:0] q_data [0:1];
    reg [15:0] q_len [0:1];
    reg q_dir [0:1];
    reg wp;
    reg rp;
    reg [1:0] cnt;
    reg [3:0] irq_st;
    reg [3:0] irq_mask;
    reg [3:0] ev;
    reg [`RLFA_NUM_LUN-1:0] lun_busy;
    reg [`RLFA_NUM_LUN-1:0] lun_set;

    wire agent_rst = !rst_n_i || br_s2;
    wire wr_ptr = reg_wr_i && hit(reg_addr_i, `RLFA_REG_REQ_PTR);
    wire wr_bell = reg_wr_i && hit(reg_addr_i, `RLFA_REG_DOORBELL);
    wire beat = mem_req_o && mem_ack_i;
    wire [31:0] word_off = {28'h0000000, widx, 2'b00};
    wire [31:0] head_addr = q_data[rp] + {14'h0000, xcnt, 2'b00};

    // Bus reset arrives from the link side; two flops before use.
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            br_s1 <= 1'b0;
            br_s2 <= 1'b0;
        end else begin
            br_s1 <= bus_reset_i;
            br_s2 <= br_s1;
        end
    end

    // One busy flag per logical unit; set on an accepted login.
    genvar g;
    generate
        for (g = 0; g < `RLFA_NUM_LUN; g = g + 1) begin : g_lun
            always @(posedge clock_i) begin
                if (agent_rst) begin
                    lun_busy[g] <= 1'b0;
                end else if (lun_set[g]) begin
                    lun_busy[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // Login flag, register writes and the single bus-master engine.
    always @(posedge clock_i) begin
        if (agent_rst) begin
            agent <= `RLFA_AG_RESET;
            eng <= `RLFA_E_IDLE;
            widx <= 2'h0;
            xcnt <= 16'h0000;
            login_pend <= 1'b0;
            login_addr <= 32'h00000000;
            resp_addr <= 32'h00000000;
            drop_addr <= 32'h00000000;
            lun <= 2'h0;
            resp_code <= `RLFA_RESP_OK;
            fetch_pend <= 1'b0;
            relink_pend <= 1'b0;
            null_seen <= 1'b0;
            fetch_addr <= 32'h00000000;
            last_addr <= 32'h00000000;
            t_link <= 32'h00000000;
            t_data <= 32'h00000000;
            q_data[0] <= 32'h00000000;
            q_data[1] <= 32'h00000000;
            q_len[0] <= 16'h0000;
            q_len[1] <= 16'h0000;
            q_dir[0] <= 1'b0;
            q_dir[1] <= 1'b0;
            wp <= 1'b0;
            rp <= 1'b0;
            cnt <= 2'h0;
            ev <= 4'h0;
            lun_set <= {`RLFA_NUM_LUN{1'b0}};
            mem_req_o <= 1'b0;
            mem_write_o <= 1'b0;
            mem_addr_o <= 32'h00000000;
            mem_wdata_o <= 32'h00000000;
            dout_o <= 32'h00000000;
            dout_valid_o <= 1'b0;
            din_take_o <= 1'b0;
        end else begin
            ev <= 4'h0;
            lun_set <= {`RLFA_NUM_LUN{1'b0}};
            dout_valid_o <= 1'b0;
            din_take_o <= 1'b0;
            // Software writes that start work.
            if (reg_wr_i && hit(reg_addr_i, `RLFA_REG_LOGIN)) begin
                login_pend <= 1'b1;
                login_addr <= reg_wdata_i;
            end
            if (wr_ptr && agent == `RLFA_AG_RESET && lun_busy != 0) begin
                agent <= `RLFA_AG_ACTIVE;
                fetch_addr <= reg_wdata_i;
                fetch_pend <= 1'b1;
                null_seen <= 1'b0;
            end
            // Reset state ignores it; Active ignores it until null seen.
            if (wr_bell && agent == `RLFA_AG_SUSP) begin
                agent <= `RLFA_AG_ACTIVE;
                relink_pend <= 1'b1;
            end else if (wr_bell && agent == `RLFA_AG_ACTIVE && null_seen) begin
                relink_pend <= 1'b1;
            end
            // A failed bus transaction ends the cycle and drops the queue.
            if (beat && mem_err_i) begin
                mem_req_o <= 1'b0;
                agent <= `RLFA_AG_RESET;
                eng <= `RLFA_E_IDLE;
                cnt <= 2'h0;
                wp <= 1'b0;
                rp <= 1'b0;
                fetch_pend <= 1'b0;
                relink_pend <= 1'b0;
                ev[`RLFA_IRQ_ERR] <= 1'b1;
            end else begin
                case (eng)
                    `RLFA_E_IDLE: begin
                        widx <= 2'h0;
                        xcnt <= 16'h0000;
                        if (login_pend) begin
                            eng <= `RLFA_E_LRD;
                        end else if (agent == `RLFA_AG_ACTIVE) begin
                            if (relink_pend) begin
                                eng <= `RLFA_E_LINK;
                            end else if (fetch_pend && !null_seen && cnt != 2'h2) begin
                                eng <= `RLFA_E_FETCH;
                            end else if (cnt != 2'h0) begin
                                // Head of queue only: ordered execution.
                                if (q_len[rp] == 16'h0000) begin
                                    eng <= `RLFA_E_STAT;
                                end else begin
                                    eng <= `RLFA_E_XFER;
                                end
                            end else if (null_seen && !wr_bell) begin
                                // A doorbell in this same cycle keeps the agent Active for its relink.
                                agent <= `RLFA_AG_SUSP;
                                ev[`RLFA_IRQ_SUSP] <= 1'b1;
                            end
                        end
                    end
                    `RLFA_E_LRD: begin
                        if (!mem_req_o) begin
                            mem_req_o <= 1'b1;
                            mem_write_o <= 1'b0;
                            mem_addr_o <= login_addr + word_off;
                        end else if (mem_ack_i) begin
                            mem_req_o <= 1'b0;
                            widx <= widx + 2'h1;
                            if (widx == 2'h0) begin
                                resp_addr <= mem_rdata_i;
                            end else if (widx == 2'h1) begin
                                drop_addr <= mem_rdata_i;
                            end else begin
                                lun <= mem_rdata_i[1:0];
                                widx <= 2'h0;
                                eng <= `RLFA_E_LWR;
                                login_pend <= 1'b0;
                                if (lun_busy[mem_rdata_i[1:0]]) begin
                                    resp_code <= `RLFA_RESP_DENIED;
                                end else begin
                                    resp_code <= `RLFA_RESP_OK;
                                end
                            end
                        end
                    end
                    `RLFA_E_LWR: begin
                        // Word 0 is the agent base, word 1 the result.
                        if (!mem_req_o) begin
                            mem_req_o <= 1'b1;
                            mem_write_o <= 1'b1;
                            mem_addr_o <= resp_addr + word_off;
                            if (widx == 2'h0) begin
                                mem_wdata_o <= `RLFA_AGENT_BASE;
                            end else begin
                                mem_wdata_o <= resp_code;
                            end
                        end else if (mem_ack_i) begin
                            mem_req_o <= 1'b0;
                            widx <= widx + 2'h1;
                            if (widx == 2'h1) begin
                                eng <= `RLFA_E_IDLE;
                                ev[`RLFA_IRQ_LOGIN] <= 1'b1;
                                if (resp_code == `RLFA_RESP_OK) begin
                                    lun_set[lun] <= 1'b1;
                                end
                            end
                        end
                    end
                    `RLFA_E_FETCH: begin
                        if (!mem_req_o) begin
                            mem_req_o <= 1'b1;
                            mem_write_o <= 1'b0;
                            mem_addr_o <= fetch_addr + word_off;
                        end else if (mem_ack_i) begin
                            mem_req_o <= 1'b0;
                            widx <= widx + 2'h1;
                            if (widx == 2'h0) begin
                                t_link <= mem_rdata_i;
                            end else if (widx == 2'h1) begin
                                t_data <= mem_rdata_i;
                            end else begin
                                // Store the block and follow its link.
                                q_data[wp] <= t_data;
                                q_len[wp] <= mem_rdata_i[15:0];
                                q_dir[wp] <= mem_rdata_i[`RLFA_DIR_BIT];
                                wp <= ~wp;
                                cnt <= cnt + 2'h1;
                                last_addr <= fetch_addr;
                                eng <= `RLFA_E_IDLE;
                                if (t_link[`RLFA_NULL_BIT]) begin
                                    null_seen <= 1'b1;
                                    fetch_pend <= 1'b0;
                                end else begin
                                    fetch_addr <= t_link;
                                end
                            end
                        end
                    end
                    `RLFA_E_XFER: begin
                        if (!mem_req_o) begin
                            mem_req_o <= 1'b1;
                            mem_addr_o <= head_addr;
                            mem_write_o <= q_dir[rp];
                            if (q_dir[rp]) begin
                                mem_wdata_o <= din_i;
                                din_take_o <= 1'b1;
                            end
                        end else if (mem_ack_i) begin
                            mem_req_o <= 1'b0;
                            xcnt <= xcnt + 16'h0001;
                            if (!q_dir[rp]) begin
                                dout_o <= mem_rdata_i;
                                dout_valid_o <= 1'b1;
                            end
                            if (xcnt == q_len[rp] - 16'h0001) begin
                                eng <= `RLFA_E_STAT;
                            end
                        end
                    end
                    `RLFA_E_STAT: begin
                        if (!mem_req_o) begin
                            mem_req_o <= 1'b1;
                            mem_write_o <= 1'b1;
                            mem_addr_o <= drop_addr;
                            mem_wdata_o <= {16'h0000, dev_status_i};
                        end else if (mem_ack_i) begin
                            mem_req_o <= 1'b0;
                            rp <= ~rp;
                            cnt <= cnt - 2'h1;
                            eng <= `RLFA_E_IDLE;
                            ev[`RLFA_IRQ_BLOCK] <= 1'b1;
                        end
                    end
                    `RLFA_E_LINK: begin
                        if (!mem_req_o) begin
                            mem_req_o <= 1'b1;
                            mem_write_o <= 1'b0;
                            mem_addr_o <= last_addr;
                        end else if (mem_ack_i) begin
                            mem_req_o <= 1'b0;
                            relink_pend <= 1'b0;
                            eng <= `RLFA_E_IDLE;
                            if (!mem_rdata_i[`RLFA_NULL_BIT]) begin
                                fetch_addr <= mem_rdata_i;
                                fetch_pend <= 1'b1;
                                null_seen <= 1'b0;
                            end
                        end
                    end
                    default: begin
                        eng <= `RLFA_E_IDLE;
                    end
                endcase
            end
        end
    end

    // Sticky interrupt status, cleared by a read; an event wins over it.
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            irq_st <= 4'h0;
            irq_mask <= `RLFA_IRQ_MASK_RST;
            irq_o <= 1'b0;
        end else begin
            if (reg_rd_i && hit(reg_addr_i, `RLFA_REG_IRQ_STAT)) begin
                irq_st <= ev;
            end else begin
                irq_st <= irq_st | ev;
            end
            if (reg_wr_i && hit(reg_addr_i, `RLFA_REG_IRQ_MASK)) begin
                irq_mask <= reg_wdata_i[3:0];
            end
            irq_o <= |(irq_st & irq_mask);
        end
    end

    // Read data stands one cycle after the read strobe.
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            if (hit(reg_addr_i, `RLFA_REG_LOGIN)) begin
                reg_rdata_o <= {resp_code[7:0], 20'h00000, lun_busy};
            end else if (hit(reg_addr_i, `RLFA_REG_REQ_PTR)) begin
                reg_rdata_o <= fetch_addr;
            end else if (hit(reg_addr_i, `RLFA_REG_STATE)) begin
                reg_rdata_o <= {21'h000000, eng, 2'h0, cnt, 1'b0, null_seen, agent};
            end else if (hit(reg_addr_i, `RLFA_REG_IRQ_STAT)) begin
                reg_rdata_o <= {28'h0000000, irq_st};
            end else if (hit(reg_addr_i, `RLFA_REG_IRQ_MASK)) begin
                reg_rdata_o <= {28'h0000000, irq_mask};
            end else begin
                reg_rdata_o <= 32'h00000000;
            end
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end

endmodule // rlfa_agent

// file: rlfa_defines.vh
`ifndef RLFA_DEFINES_VH
`define RLFA_DEFINES_VH

// Register byte offsets on the plain register port.
`define RLFA_REG_LOGIN 8'h00
`define RLFA_REG_REQ_PTR 8'h04
`define RLFA_REG_DOORBELL 8'h08
`define RLFA_REG_STATE 8'h0C
`define RLFA_REG_IRQ_STAT 8'h10
`define RLFA_REG_IRQ_MASK 8'h14

// Interrupt status bit positions.
`define RLFA_IRQ_LOGIN 0
`define RLFA_IRQ_BLOCK 1
`define RLFA_IRQ_SUSP 2
`define RLFA_IRQ_ERR 3
`define RLFA_IRQ_MASK_RST 4'h0

// Command fetch agent states.
`define RLFA_AG_RESET 2'h0
`define RLFA_AG_ACTIVE 2'h1
`define RLFA_AG_SUSP 2'h2

// Engine states.
`define RLFA_E_IDLE 3'h0
`define RLFA_E_LRD 3'h1
`define RLFA_E_LWR 3'h2
`define RLFA_E_FETCH 3'h3
`define RLFA_E_XFER 3'h4
`define RLFA_E_STAT 3'h5
`define RLFA_E_LINK 3'h6

// Request block layout in words: link, data address, direction and length.
`define RLFA_RB_WORDS 2'h3
`define RLFA_LOGIN_WORDS 2'h3
`define RLFA_NULL_BIT 31
`define RLFA_DIR_BIT 31

// Login response codes and the command agent base address.
`define RLFA_RESP_OK 32'h00000000
`define RLFA_RESP_DENIED 32'h00000004
`define RLFA_AGENT_BASE 32'hF0010000
`define RLFA_NUM_LUN 4

`endif

// file: rlfa_agent_chk.sv
`include "rlfa_defines.vh"
module rlfa_agent_chk (
    input wire clock_i,
    input wire rst_n_i,
    input wire bus_reset_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [31:0] reg_rdata_o,
    input wire mem_req_o,
    input wire mem_write_o,
    input wire [31:0] mem_addr_o,
    input wire [31:0] mem_wdata_o,
    input wire mem_ack_i,
    input wire [31:0] din_i,
    input wire din_take_o,
    input wire dout_valid_o,
    input wire irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_i);
    endclocking
    // A held reset clears the request and data strobes, the interrupt and the read data by the next edge.
    property p_rst;
        !rst_n_i |=> !mem_req_o && !din_take_o && !dout_valid_o && !irq_o && reg_rdata_o == 32'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    // A bus reset that has passed the synchroniser stops all traffic.
    sequence s_bus_rst;
        bus_reset_i [*4];
    endsequence
    property p_bus_rst;
        disable iff (!rst_n_i) s_bus_rst |=> !mem_req_o && !din_take_o && !dout_valid_o;
    endproperty
    a_bus_rst: assert property (p_bus_rst) else $error("bus reset left traffic running");
    // Read data stand only in the cycle after a read strobe.
    property p_rd_idle;
        disable iff (!rst_n_i) !reg_rd_i |=> reg_rdata_o == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    // The agent state field never holds the unused code.
    property p_state;
        disable iff (!rst_n_i) reg_rd_i && reg_addr_i == `RLFA_REG_STATE |=> reg_rdata_o[1:0] != 2'h3;
    endproperty
    a_state: assert property (p_state) else $error("agent state out of range");
    // A pending transaction keeps its address, direction and data.
    property p_hold;
        disable iff (!rst_n_i) mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
            && $stable(mem_write_o) && $stable(mem_wdata_o);
    endproperty
    a_hold: assert property (p_hold) else $error("transaction changed before ack");
    // The request drops right after its acknowledge.
    property p_gap;
        disable iff (!rst_n_i) mem_ack_i |=> !mem_req_o;
    endproperty
    a_gap: assert property (p_gap) else $error("request held after ack");
    // A pushed word goes out as a block write of that word.
    sequence s_push_out;
        ##[0:8] (mem_req_o && mem_write_o);
    endsequence
    property p_take;
        disable iff (!rst_n_i) din_take_o |-> mem_wdata_o == $past(din_i) ##0 s_push_out;
    endproperty
    a_take: assert property (p_take) else $error("pushed word not written out");
    // One block moves data in one direction only.
    property p_excl;
        disable iff (!rst_n_i) !(din_take_o && dout_valid_o);
    endproperty
    a_excl: assert property (p_excl) else $error("pull and push at once");
    // Clearing the mask drops the interrupt after its one-cycle lag.
    property p_mask;
        disable iff (!rst_n_i) reg_wr_i && reg_addr_i == `RLFA_REG_IRQ_MASK && reg_wdata_i[3:0] == 4'h0
            |=> ##1 !irq_o;
    endproperty
    a_mask: assert property (p_mask) else $error("interrupt high with empty mask");
endmodule // rlfa_agent_chk

bind rlfa_agent rlfa_agent_chk rlfa_agent_chk_inst (.clock_i, .rst_n_i, .bus_reset_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .mem_req_o, .mem_write_o, .mem_addr_o,
    .mem_wdata_o, .mem_ack_i, .din_i, .din_take_o, .dout_valid_o, .irq_o);

// file: rlfa_host_mem.sv
module rlfa_host_mem (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic mem_req_i,
    input wire logic mem_write_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    input wire logic slow_i,
    input wire logic fail_i,
    output logic mem_ack_o,
    output logic mem_err_o,
    output logic [31:0] mem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:255];
    logic [1:0] wait_q;
    logic done;
    // Answers each request once, promptly or after three extra cycles.
    always @(posedge clock_i) begin
        mem_ack_o <= 1'b0;
        mem_err_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        if (!rst_n_i || !mem_req_i) begin
            wait_q <= 2'h0;
            done <= 1'b0;
        end else if (!done) begin
            if (slow_i && wait_q != 2'h3) begin
                wait_q <= wait_q + 2'h1;
            end else begin
                mem_ack_o <= 1'b1;
                mem_err_o <= fail_i;
                done <= 1'b1;
                if (mem_write_i) mem[mem_addr_i[9:2]] <= mem_wdata_i;
                else mem_rdata_o <= mem[mem_addr_i[9:2]];
            end
        end
    end
endmodule // rlfa_host_mem

// file: test_rlfa_agent.sv
`include "rlfa_defines.vh"
module test_rlfa_agent;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i, rst_n_i, bus_reset_i, reg_wr_i, reg_rd_i, slow, fail;
    logic mem_req_o, mem_write_o, mem_ack_i, mem_err_i, dout_valid_o, din_take_o, irq_o;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i, dout_o, din_i, din_q, seed, v;
    logic [15:0] dev_status_i;
    logic [31:0] pulled[$], pushed[$];
    int mismatches, total_checks, acks;
    rlfa_agent rlfa_agent_inst (.clock_i, .rst_n_i, .bus_reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .mem_req_o, .mem_write_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i,
        .mem_err_i, .mem_rdata_i, .dout_o, .dout_valid_o, .din_i, .din_take_o, .dev_status_i, .irq_o);
    rlfa_host_mem rlfa_host_mem_inst (.clock_i, .rst_n_i, .mem_req_i(mem_req_o), .mem_write_i(mem_write_o),
        .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .slow_i(slow), .fail_i(fail),
        .mem_ack_o(mem_ack_i), .mem_err_o(mem_err_i), .mem_rdata_o(mem_rdata_i));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] got(input logic [31:0] a);
        return rlfa_host_mem_inst.mem[a[9:2]];
    endfunction
    task automatic put(input logic [31:0] a, input logic [31:0] d);
        rlfa_host_mem_inst.mem[a[9:2]] = d;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        @(posedge clock_i);
        v = reg_rdata_o;
    endtask
    task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
        for (int i = 0; i < 400; i++) begin
            rd(a);
            if ((v & m) === e) break;
        end
        chk(n, v & m, e);
    endtask
    task automatic login(input logic [31:0] e);
        put(32'h84, 32'hFFFFFFFF);
        wr(`RLFA_REG_LOGIN, 32'h40);
        wait_reg(`RLFA_REG_IRQ_STAT, 32'h1, 32'h1, "login_done");
        chk("login_base", got(32'h80), 32'hF0010000);
        chk("login_result", got(32'h84), e);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Free-running 100 MHz clock.
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // Records pulled and pushed words, counts transactions and feeds fresh push data.
    always @(posedge clock_i) begin
        if (dout_valid_o === 1'b1) pulled.push_back(dout_o);
        if (din_take_o === 1'b1) pushed.push_back(din_q); // The design took din_i one edge earlier.
        if (mem_ack_i === 1'b1) acks++;
        din_q <= din_i;
        din_i <= rnd();
    end
    // Cuts a hung run short.
    initial begin
        repeat (60000) @(posedge clock_i);
        mismatches++;
        end_sim();
    end
    // Main sequence.
    initial begin
        seed = 32'h2B;
        {rst_n_i, bus_reset_i, reg_wr_i, reg_rd_i, slow, fail} = 6'h0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        din_i = 32'h0;
        v = rnd();
        dev_status_i = v[15:0];
        for (int i = 0; i < 256; i++) put(i * 4, rnd());
        put(32'h40, 32'h80);
        put(32'h44, 32'hA0);
        put(32'h48, 32'h0);
        put(32'h100, 32'h110);
        put(32'h104, 32'h200);
        put(32'h108, 32'h2);
        put(32'h110, 32'h80000000);
        put(32'h114, 32'h300);
        put(32'h118, 32'h80000002);
        put(32'h120, 32'h80000000);
        put(32'h124, 32'h208);
        put(32'h128, 32'h1);
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        rd(`RLFA_REG_STATE);
        chk("reset_state", v & 32'h3, 32'h0);
        rd(`RLFA_REG_IRQ_MASK);
        chk("mask_reset", v, 32'h0);
        rd(8'hFC);
        chk("unmapped", v, 32'h0);
        wr(`RLFA_REG_REQ_PTR, 32'h100);
        wr(`RLFA_REG_DOORBELL, 32'h1);
        rd(`RLFA_REG_STATE);
        chk("no_login_state", v & 32'h3, 32'h0);
        $display("test reset done");
        login(`RLFA_RESP_OK);
        login(`RLFA_RESP_DENIED);
        $display("test login done");
        slow <= 1'b1;
        acks = 0;
        wr(`RLFA_REG_REQ_PTR, 32'h100);
        rd(`RLFA_REG_STATE);
        chk("active", v & 32'h3, 32'h1);
        wr(`RLFA_REG_DOORBELL, 32'h1);
        wait_reg(`RLFA_REG_STATE, 32'h3, 32'h2, "suspended");
        chk("acks_list", acks, 32'd12);
        chk("pull0", pulled[0], got(32'h200));
        chk("pull1", pulled[1], got(32'h204));
        chk("push0", got(32'h300), pushed[0]);
        chk("push1", got(32'h304), pushed[1]);
        chk("status", got(32'hA0), {16'h0, dev_status_i});
        wr(`RLFA_REG_IRQ_MASK, 32'h4);
        repeat (2) @(posedge clock_i);
        chk("irq_high", {31'h0, irq_o}, 32'h1);
        rd(`RLFA_REG_IRQ_STAT);
        chk("susp_bit", v & 32'h4, 32'h4);
        repeat (2) @(posedge clock_i);
        chk("irq_low", {31'h0, irq_o}, 32'h0);
        $display("test list done");
        slow <= 1'b0;
        acks = 0;
        put(32'h110, 32'h120);
        wr(`RLFA_REG_DOORBELL, 32'h1);
        wait_reg(`RLFA_REG_STATE, 32'h3, 32'h2, "resuspended");
        chk("acks_append", acks, 32'd6);
        chk("pull2", pulled[2], got(32'h208));
        $display("test append done");
        bus_reset_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        bus_reset_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        rd(`RLFA_REG_STATE);
        chk("bus_reset_state", v & 32'h3, 32'h0);
        login(`RLFA_RESP_OK);
        fail <= 1'b1;
        wr(`RLFA_REG_REQ_PTR, 32'h100);
        wait_reg(`RLFA_REG_IRQ_STAT, 32'h8, 32'h8, "err_bit");
        rd(`RLFA_REG_STATE);
        chk("err_state", v & 32'h3, 32'h0);
        fail <= 1'b0;
        wr(`RLFA_REG_IRQ_MASK, 32'h0);
        repeat (3) @(posedge clock_i);
        $display("test error done");
        end_sim();
    end
endmodule // test_rlfa_agent
